// file: rtl/nvm_pkg.sv
// Constants and types shared by the two-wire memory slave
// What this block does
// - The memory holds 131072 bytes reachable over the serial link.
// - The block is only ever a slave; the master starts every transfer and picks the slave.
// - Two strap inputs pick one of four slave identities on a shared bus.
// - The block answers only when the received select bits equal its straps, else it idles.
// - An unconnected strap input reads as low.
// - The data line carries address, write and read data and is only pulled low or released.
// - Incoming bits are sampled on a clock rise and outgoing bits change on a clock fall.
// - With write protect high no byte is written to the array.
// - With write protect low every location may be written.
// - Reads work whatever level write protect has.
// - An unconnected write protect input reads as low, so writes stay enabled.
package nvm_pkg;
    localparam int          MEM_WORDS = 131072;
    localparam int          ADDR_W    = 17;
    localparam int          DATA_W    = 8;
    // Upper nibble of the select byte; the value is arbitrary
    localparam logic [3:0]  DEV_CODE  = 4'h5;
    localparam logic [3:0]  CNT_RST   = 4'h0;
    localparam logic [3:0]  LAST_BIT  = 4'h7;
    localparam logic [3:0]  ACK_SLOT  = 4'h8;
    localparam logic [16:0] ADDR_RST  = 17'h00000;
    localparam logic [16:0] ADDR_TOP  = 17'h1ffff;
    localparam logic [7:0]  DATA_RST  = 8'h00;
    localparam logic [2:0]  BUS_RST   = 3'h7;
    localparam logic [2:0]  PIN_RST   = 3'h0;
    // Master side clock ceilings, kept for reference by the bench
    localparam int SYS_CLK_KHZ     = 100000;
    localparam int SCL_HS_MAX_KHZ  = 3400;
    localparam int SCL_FMP_MAX_KHZ = 1000;
    localparam int SCL_HS_MIN_CYC  = (SYS_CLK_KHZ + SCL_HS_MAX_KHZ - 1) / SCL_HS_MAX_KHZ;
    localparam int SCL_FMP_MIN_CYC = (SYS_CLK_KHZ + SCL_FMP_MAX_KHZ - 1) / SCL_FMP_MAX_KHZ;

    typedef enum logic [2:0] {IDLE, DEV, AHI, ALO, WRITE, READ} phase_t;

    typedef struct packed {
        phase_t      st;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [16:0] addr;
        logic        rw;
        logic        rise_seen;
        logic        oe;
        logic        scl_p;
        logic        sda_p;
        logic        we;
        logic [16:0] waddr;
        logic [7:0]  wdata;
    } ctl_t;

    localparam ctl_t CTL_RST = '{IDLE, CNT_RST, DATA_RST, ADDR_RST, 1'b0, 1'b0,
                                 1'b0, 1'b1, 1'b1, 1'b0, ADDR_RST, DATA_RST};
endpackage

// file: rtl/pin_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
    import nvm_pkg::*;
#(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
)(
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] f;
    } sync_t;

    sync_t r_q;
    sync_t r_d;

    // Output moves only once stages two and three agree
    always_comb
    begin
        r_d    = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        for (int i = 0; i < W; i++)
        begin
            if (r_q.s2[i] == r_q.s3[i])
            begin
                r_d.f[i] = r_q.s2[i];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            r_q <= {RST, RST, RST, RST};
        else
            r_q <= r_d;
    end

    assign q = r_q.f;
endmodule

// file: rtl/nvm_array.sv
// Byte array with one write port and a registered read port
`timescale 1ns/1ps
module nvm_array
    import nvm_pkg::*;
#(
    parameter int DEPTH = MEM_WORDS,
    parameter int AW    = ADDR_W,
    parameter int DW    = DATA_W
)(
    input  wire logic          sys_clk,
    input  wire logic          nrst,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    // Contents are not reset; nonvolatile store keeps what it had
    logic [DW-1:0] mem [0:DEPTH-1];

    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    // Read runs every cycle so a byte is ready long before it is shifted
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            rd_data <= '0;
        else
            rd_data <= mem[rd_addr];
    end
endmodule

// file: rtl/nvm_slave.sv
// Two-wire slave front end with its byte array
`timescale 1ns/1ps
module nvm_slave
    import nvm_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic scl_clk,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    input  wire logic identity_strap_low,
    input  wire logic identity_strap_high,
    input  wire logic write_protect
);
    localparam int ACK_WAIT = 1000;

    typedef struct packed {
        logic smp;
    } link_t;

    link_t       l_q;
    link_t       l_d;
    ctl_t        r_q;
    ctl_t        r_d;
    logic        scl_f;
    logic        sda_f;
    logic        bit_f;
    logic        wp_f;
    logic        hi_f;
    logic        lo_f;
    logic [7:0]  rd_data;
    logic [7:0]  nb;
    logic [16:0] addr_inc;
    logic        rise_ev;
    logic        fall_ev;
    logic        start_ev;
    logic        stop_ev;
    logic        bit_done;
    logic        match;

    // Link side: one flop that takes the data line on each clock rise
    always_comb
    begin
        l_d     = l_q;
        l_d.smp = sda_i;
    end

    // Held for a whole clock period, so the fall event reads it settled
    always_ff @(posedge scl_clk)
    begin
        l_q <= l_d;
    end

    // Bus pins and the sampled bit into the system clock
    pin_sync #(
        .W   (3),
        .RST (BUS_RST)
    ) u_bus_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       ({scl_clk, sda_i, l_q.smp}),
        .q       ({scl_f, sda_f, bit_f})
    );

    // Straps and write protect; open pads are pulled low outside
    pin_sync #(
        .W   (3),
        .RST (PIN_RST)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       ({write_protect, identity_strap_high, identity_strap_low}),
        .q       ({wp_f, hi_f, lo_f})
    );

    nvm_array u_array (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .wr_en   (r_q.we),
        .wr_addr (r_q.waddr),
        .wr_data (r_q.wdata),
        .rd_addr (r_q.addr),
        .rd_data (rd_data)
    );

    // Bus events from the filtered pin levels
    assign rise_ev  = scl_f && !r_q.scl_p;
    assign fall_ev  = !scl_f && r_q.scl_p;
    assign start_ev = scl_f && r_q.scl_p && r_q.sda_p && !sda_f;
    assign stop_ev  = scl_f && r_q.scl_p && !r_q.sda_p && sda_f;
    // A fall only ends a bit if a rise came since the start or since the previous bit ended
    assign bit_done = fall_ev && r_q.rise_seen;
    assign nb       = {r_q.sh[6:0], bit_f};
    // Pad pull-down makes an open strap a plain low here
    assign match    = (nb[7:4] == DEV_CODE) && (nb[2] == hi_f) && (nb[1] == lo_f);
    // Address runs on and wraps at the top of the array
    assign addr_inc = (r_q.addr == ADDR_TOP) ? ADDR_RST : r_q.addr + 17'h00001;

    // Protocol engine, stepping on bus events only
    always_comb
    begin
        r_d       = r_q;
        r_d.we    = 1'b0;
        r_d.scl_p = scl_f;
        r_d.sda_p = sda_f;
        if (rise_ev)
            r_d.rise_seen = 1'b1;
        if (start_ev)
        begin
            r_d.st        = DEV;
            r_d.cnt       = CNT_RST;
            r_d.oe        = 1'b0;
            r_d.rise_seen = 1'b0;
        end
        else if (stop_ev)
        begin
            r_d.st  = IDLE;
            r_d.cnt = CNT_RST;
            r_d.oe  = 1'b0;
        end
        else if (bit_done)
        begin
            r_d.rise_seen = 1'b0;
            unique case (r_q.st)
                IDLE:
                begin
                    r_d.oe = 1'b0;
                end
                READ:
                begin
                    if (r_q.cnt == ACK_SLOT)
                    begin
                        // Master acknowledge low asks for the next byte
                        if (!bit_f)
                        begin
                            r_d.sh   = rd_data;
                            r_d.oe   = !rd_data[7];
                            r_d.addr = addr_inc;
                            r_d.cnt  = CNT_RST;
                        end
                        else
                        begin
                            r_d.st = IDLE;
                        end
                    end
                    else if (r_q.cnt == LAST_BIT)
                    begin
                        r_d.oe  = 1'b0;
                        r_d.cnt = ACK_SLOT;
                    end
                    else
                    begin
                        r_d.sh  = {r_q.sh[6:0], 1'b0};
                        r_d.oe  = !r_q.sh[6];
                        r_d.cnt = r_q.cnt + 4'h1;
                    end
                end
                DEV, AHI, ALO, WRITE:
                begin
                    if (r_q.cnt == ACK_SLOT)
                    begin
                        // Acknowledge slot over, let the line go unless a read starts and drives its first bit
                        r_d.oe  = 1'b0;
                        r_d.cnt = CNT_RST;
                        if (r_q.st == DEV && r_q.rw)
                        begin
                            r_d.st   = READ;
                            r_d.sh   = rd_data;
                            r_d.oe   = !rd_data[7];
                            r_d.addr = addr_inc;
                        end
                        else if (r_q.st == DEV)
                            r_d.st = AHI;
                        else if (r_q.st == AHI)
                            r_d.st = ALO;
                        else
                            r_d.st = WRITE;
                    end
                    else if (r_q.cnt == LAST_BIT)
                    begin
                        r_d.sh  = nb;
                        r_d.cnt = ACK_SLOT;
                        r_d.oe  = 1'b1;
                        if (r_q.st == DEV)
                        begin
                            if (match)
                            begin
                                r_d.addr[16] = nb[3];
                                r_d.rw       = nb[0];
                            end
                            else
                            begin
                                r_d.st = IDLE;
                                r_d.oe = 1'b0;
                            end
                        end
                        else if (r_q.st == AHI)
                            r_d.addr[15:8] = nb;
                        else if (r_q.st == ALO)
                            r_d.addr[7:0] = nb;
                        else
                        begin
                            // Protected bytes are acknowledged and dropped
                            r_d.we    = !wp_f;
                            r_d.waddr = r_q.addr;
                            r_d.wdata = nb;
                            r_d.addr  = addr_inc;
                        end
                    end
                    else
                    begin
                        r_d.sh  = nb;
                        r_d.cnt = r_q.cnt + 4'h1;
                    end
                end
                default:
                begin
                    r_d.st = IDLE;
                    r_d.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            r_q <= CTL_RST;
        else
            r_q <= r_d;
    end

    // Open drain: the line is only ever pulled low
    assign sda_o  = 1'b0;
    assign sda_oe = r_q.oe;

    sequence s_byte_done;
        bit_done && r_q.cnt == LAST_BIT;
    endsequence

    sequence s_slot_end;
        ##[1:ACK_WAIT] bit_done;
    endsequence

    property p_ack_hold;
        @(posedge sys_clk) disable iff (!nrst)
        ($rose(r_q.oe) && r_q.cnt == ACK_SLOT && r_q.st != READ)
            |-> r_q.oe throughout s_slot_end;
    endproperty

    start_frames_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        start_ev |=> r_q.st == DEV && r_q.cnt == CNT_RST && !sda_oe)
        else $error("start did not open a frame");

    strap_miss_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_byte_done and (r_q.st == DEV && !match)) |=> r_q.st == IDLE && !sda_oe)
        else $error("foreign select code was answered");

    strap_hit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_byte_done and (r_q.st == DEV && match))
            |=> sda_oe && r_q.addr[16] == $past(nb[3]) && r_q.rw == $past(nb[0]))
        else $error("own select code not acknowledged");

    wp_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        r_q.we |-> !$past(wp_f))
        else $error("write while protected");

    wp_open_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_byte_done and (r_q.st == WRITE && !wp_f))
            |=> r_q.we && r_q.wdata == $past(nb) && r_q.waddr == $past(r_q.addr))
        else $error("unprotected byte not written");

    read_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (bit_done && r_q.st == READ && r_q.cnt == ACK_SLOT && !bit_f)
            |=> r_q.sh == $past(rd_data) && sda_oe == !$past(rd_data[7]))
        else $error("read byte not loaded");

    oe_on_fall_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $changed(sda_oe) |-> $past(fall_ev) || $past(start_ev) || $past(stop_ev))
        else $error("data line changed away from a clock fall");

    ack_hold_a: assert property (p_ack_hold)
        else $error("acknowledge dropped before the slot ended");

    addr_wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_byte_done and (r_q.st == WRITE && r_q.addr == ADDR_TOP))
            |=> r_q.addr == ADDR_RST)
        else $error("address did not wrap");

    msb_first_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_byte_done and (r_q.st == AHI)) |=> r_q.addr[15:8] == $past(nb))
        else $error("address byte not taken msb first");

    // Last read bit must free the line so the master can answer
    read_free_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_byte_done and (r_q.st == READ)) |=> !sda_oe && r_q.cnt == ACK_SLOT)
        else $error("read byte did not free the line for the acknowledge");

    // A stop ends any frame and lets the line go
    stop_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        stop_ev |=> r_q.st == IDLE && !sda_oe)
        else $error("stop did not end the frame");

    // Master refusal after a read byte ends the transfer
    read_nack_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (bit_done && r_q.st == READ && r_q.cnt == ACK_SLOT && bit_f)
            |=> r_q.st == IDLE && !sda_oe)
        else $error("read went on after the master refused");
endmodule

// file: verification/two_wire_master.sv
// Behavioural two-wire bus master that makes the link clock and drives data
`timescale 1ns/1ps
module two_wire_master
(
    output logic      scl,
    output logic      oe,
    input  wire logic sda
);
    // Bus idles released, clock parked high between frames
    initial
    begin
        scl = 1'b1;
        oe  = 1'b0;
    end

    // One bit slot; data moves only while the clock is low
    // Slot is faster than a real master may run, to stress the filters
    task automatic slot(input logic b, output logic r);
        #40 oe = ~b;
        #40 scl = 1'b1;
        #80 r = sda;
        scl = 1'b0;
    endtask

    // Start or repeated start; odd offset keeps the link phase unrelated
    task automatic start();
        #40.3 oe = 1'b0;
        #40 scl = 1'b1;
        #80 oe = 1'b1;
        #80 scl = 1'b0;
    endtask

    // Stop leaves the clock standing high
    task automatic stop();
        #40 oe = 1'b1;
        #40 scl = 1'b1;
        #80 oe = 1'b0;
        #80;
    endtask

    // Byte out, msb first, then listen for the acknowledge
    task automatic send(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            slot(v[i], r);
        slot(1'b1, r);
        ack = ~r;
    endtask

    // Byte in, msb first; releasing the ninth slot ends a read
    task automatic recv(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            slot(1'b1, r);
            v[i] = r;
        end
        slot(last, r);
    endtask
endmodule

// file: verification/serial_nv_memory_slave_port_test.sv
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
module serial_nv_memory_slave_port_test;
    import nvm_pkg::*;
    logic       sys_clk   = 1'b0;
    logic       nrst      = 1'b0;
    logic       sl        = 1'b0;
    logic       sh        = 1'b0;
    logic       wp        = 1'b0;
    logic       scl;
    logic       m_oe;
    logic       sda_o;
    logic       sda_oe;
    wire        sda_w     = ~(m_oe | sda_oe);
    logic [7:0] ref_mem [int];
    int         error_cnt = 0;
    int         compares  = 0;

    always #5 sys_clk = ~sys_clk;

    nvm_slave nvm_slave_inst (
        .sys_clk(sys_clk), .nrst(nrst), .scl_clk(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .identity_strap_low(sl),
        .identity_strap_high(sh), .write_protect(wp));

    two_wire_master two_wire_master_inst (.scl(scl), .oe(m_oe), .sda(sda_w));

    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic summarize();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Slave may only start pulling while the clock is low, and never drives high
    always @(posedge sda_oe)
    begin
        check("pull_edge", 8'h00, {7'h0, scl});
        check("sda_o", 8'h00, {7'h0, sda_o});
    end

    function automatic logic [7:0] sel(input logic [16:0] a, input logic rw);
        return {DEV_CODE, a[16], sh, sl, rw};
    endfunction

    task automatic set_addr(input logic [16:0] a);
        logic k;
        two_wire_master_inst.start();
        two_wire_master_inst.send(sel(a, 1'b0), k);
        check("sel_ack", 8'h01, {7'h0, k});
        two_wire_master_inst.send(a[15:8], k);
        check("ahi_ack", 8'h01, {7'h0, k});
        two_wire_master_inst.send(a[7:0], k);
        check("alo_ack", 8'h01, {7'h0, k});
    endtask

    // Burst write; with rnd set each byte gets its own protect level
    task automatic wr(input logic [16:0] a, input int n, input logic rnd);
        logic [7:0] d;
        logic       k;
        set_addr(a);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom);
            @(negedge sys_clk) wp = rnd & 1'($urandom);
            two_wire_master_inst.send(d, k);
            check("data_ack", 8'h01, {7'h0, k});
            if (!wp)
                ref_mem[a] = d;
            a = a + 17'h1;
        end
        two_wire_master_inst.stop();
    endtask

    // Random read; protect level is random since reads ignore it
    task automatic rd(input logic [16:0] a, input int n);
        logic [7:0] d;
        logic       k;
        @(negedge sys_clk) wp = 1'($urandom);
        set_addr(a);
        two_wire_master_inst.start();
        two_wire_master_inst.send(sel(a, 1'b1), k);
        check("rsel_ack", 8'h01, {7'h0, k});
        for (int i = 0; i < n; i++)
        begin
            two_wire_master_inst.recv(i == n - 1, d);
            if (ref_mem.exists(a))
                check("rd_data", ref_mem[a], d);
            a = a + 17'h1;
        end
        two_wire_master_inst.stop();
    endtask

    task automatic refuse(input logic [7:0] s);
        logic k;
        two_wire_master_inst.start();
        two_wire_master_inst.send(s, k);
        check("nack", 8'h00, {7'h0, k});
        two_wire_master_inst.stop();
    endtask

    // Main sequence: every identity, protected bursts, refusals, top wrap
    initial
    begin
        logic [16:0] a;
        void'($urandom(32'hfbfe));
        repeat (8) @(negedge sys_clk);
        check("oe_rst", 8'h00, {7'h0, sda_oe});
        nrst = 1'b1;
        repeat (6) @(negedge sys_clk);
        for (int c = 0; c < 4; c++)
        begin
            @(negedge sys_clk) {sh, sl} = c[1:0];
            a = 17'($urandom);
            wr(a, 6, 1'b0);
            wr(a, 6, 1'b1);
            rd(a, 6);
            refuse(sel(a, 1'b0) ^ {5'h0, 2'(1 + $urandom % 3), 1'b0});
        end
        refuse(sel(a, 1'b0) ^ 8'h10);
        // Second reset mid-run with the bus idle; array keeps its contents
        @(negedge sys_clk) nrst = 1'b0;
        repeat (8) @(negedge sys_clk);
        check("oe_rst2", 8'h00, {7'h0, sda_oe});
        nrst = 1'b1;
        repeat (6) @(negedge sys_clk);
        @(negedge sys_clk) wp = 1'b0;
        wr(ADDR_TOP, 3, 1'b0);
        rd(ADDR_TOP, 3);
        summarize();
    end

    // Hang guard
    initial
    begin
        #800000;
        error_cnt++;
        $display("mismatch watchdog expected done seen hang");
        summarize();
    end
endmodule
